// ==== logic/pie_consts.svh ====
// constants for the power-event interrupt logic
`ifndef PIE_CONSTS_SVH
`define PIE_CONSTS_SVH
`define PIE_CMD_SUMMARY 8'h00
`define PIE_CMD_MASK 8'h01
`define PIE_CMD_PWR_EVENT 8'h02
`define PIE_CMD_PWR_EVENT_CLR 8'h03
`define PIE_BIT_SUPPLY 7
`define PIE_BIT_START 6
`define PIE_BIT_OVERCUR 5
`define PIE_BIT_CLASS 4
`define PIE_BIT_DETECT 3
`define PIE_BIT_DISC 2
`define PIE_BIT_PGOOD 1
`define PIE_BIT_PENABLE 0
`define PIE_MASK_RST 8'h80
`define PIE_SUMMARY_RST 8'h80
`define PIE_PWR_EVENT_RST 8'h00
`endif

// ==== logic/pie_pkg.sv ====
// types for the power-event interrupt logic
package pie_pkg;
  typedef logic [7:0] pie_byte_t;
  typedef logic [3:0] pie_chan_t;
  typedef enum logic [1:0] {
    PIE_IDLE = 2'b00,
    PIE_BUSY = 2'b01
  } pie_rd_state_t;
endpackage : pie_pkg

// ==== logic/pie_sticky_bit.sv ====
// one sticky event flag where a set beats a clear
`timescale 1ns/1ps
module pie_sticky_bit (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // control
  input wire logic rstVal,
  input wire logic setEvt,
  input wire logic clrEvt,
  // state
  output logic flag
);
  typedef struct packed {
    logic flag;
  } pie_sticky_t;
  pie_sticky_t st_r;
  pie_sticky_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (clrEvt) begin
      st_nxt.flag = 1'b0;
    end
    // a set in the clearing cycle survives
    if (setEvt) begin
      st_nxt.flag = 1'b1;
    end
  end
  // reset value is a per-instance tie-off, so a flag tied to 1 stays set until a real clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r.flag <= rstVal;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign flag = st_r.flag;
endmodule : pie_sticky_bit

// ==== logic/pie_interrupt_event_logic.sv ====
// interrupt summary, mask and power-event register with active-low output
`timescale 1ns/1ps
`include "pie_consts.svh"
module pie_interrupt_event_logic (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register access, one command per strobe
  input wire logic regRd,
  input wire logic regWr,
  input wire logic [7:0] regCmd,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // summary clear requests from other event registers and reset register
  input wire logic summaryClearAll,
  input wire logic startFaultRead,
  input wire logic overcurFaultRead,
  input wire logic detectEventRead,
  input wire logic faultEventRead,
  // supply and memory faults
  input wire logic thermalShutdownFlag,
  input wire logic digitalSupplyUndervoltage,
  input wire logic digitalSupplyWarning,
  input wire logic powerSupplyUndervoltage,
  input wire logic programMemoryFault,
  // per-channel event levels
  input wire logic [3:0] channelStartFault,
  input wire logic [3:0] channelOverloadCut,
  input wire logic [1:0] pairedChannelOverloadCut,
  input wire logic [3:0] channelCurrentLimitFault,
  input wire logic [3:0] channelClassificationEvent,
  input wire logic [3:0] channelDetectionEvent,
  input wire logic [3:0] channelDisconnectEvent,
  // per-channel change pulses
  input wire logic [3:0] channelPowerGoodChange,
  input wire logic [3:0] channelPowerEnableChange,
  // global enable from the general mask register
  input wire logic globalInterruptEnable,
  // interrupt pin, active low
  output logic intOut_n
);
  typedef struct packed {
    pie_pkg::pie_byte_t mask;
    pie_pkg::pie_byte_t rdData;
    logic rdValid;
    logic intN;
  } pie_state_t;
  pie_state_t st_r;
  pie_state_t st_nxt;

  // ----------------------------------------
  // power-event flags
  // ----------------------------------------
  logic pwrClrRead;
  logic [7:0] pwrEvt;
  logic [7:0] pwrSet;
  assign pwrClrRead = regRd && (regCmd == `PIE_CMD_PWR_EVENT_CLR);
  assign pwrSet = {channelPowerGoodChange, channelPowerEnableChange};

  // ----------------------------------------
  // summary flags, sticky until cleared
  // ----------------------------------------
  logic [7:0] sumSet;
  logic [7:0] sumClr;
  logic [7:0] summary;
  always_comb begin
    sumSet = 8'h00;
    sumSet[`PIE_BIT_SUPPLY] = thermalShutdownFlag | digitalSupplyUndervoltage
      | digitalSupplyWarning | powerSupplyUndervoltage | programMemoryFault;
    sumSet[`PIE_BIT_START] = |channelStartFault;
    sumSet[`PIE_BIT_OVERCUR] = (|channelOverloadCut) | (|pairedChannelOverloadCut)
      | (|channelCurrentLimitFault);
    sumSet[`PIE_BIT_CLASS] = |channelClassificationEvent;
    sumSet[`PIE_BIT_DETECT] = |channelDetectionEvent;
    sumSet[`PIE_BIT_DISC] = |channelDisconnectEvent;
    // a clearing read must not re-set from the bits it is wiping, or the pin sticks
    sumSet[`PIE_BIT_PGOOD] = (|pwrEvt[7:4]) & ~pwrClrRead;
    sumSet[`PIE_BIT_PENABLE] = (|pwrEvt[3:0]) & ~pwrClrRead;
  end
  always_comb begin
    sumClr = {8{summaryClearAll}};
    sumClr[`PIE_BIT_SUPPLY] = summaryClearAll;
    sumClr[`PIE_BIT_START] = summaryClearAll | startFaultRead;
    sumClr[`PIE_BIT_OVERCUR] = summaryClearAll | overcurFaultRead | faultEventRead;
    sumClr[`PIE_BIT_CLASS] = summaryClearAll | detectEventRead;
    sumClr[`PIE_BIT_DETECT] = summaryClearAll | detectEventRead;
    sumClr[`PIE_BIT_DISC] = summaryClearAll | faultEventRead;
    sumClr[`PIE_BIT_PGOOD] = summaryClearAll | pwrClrRead;
    sumClr[`PIE_BIT_PENABLE] = summaryClearAll | pwrClrRead;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : gPwr
      pie_sticky_bit uPwr (
        .clock(clock),
        .sys_rst(sys_rst),
        .rstVal(1'b0),
        .setEvt(pwrSet[gi]),
        .clrEvt(pwrClrRead),
        .flag(pwrEvt[gi])
      );
    end
    for (gi = 0; gi < 8; gi++) begin : gSum
      // power-event bits set the summary one cycle after they set, two cycles after the channel pulse
      pie_sticky_bit uSum (
        .clock(clock),
        .sys_rst(sys_rst),
        .rstVal(gi == `PIE_BIT_SUPPLY),
        .setEvt(sumSet[gi]),
        .clrEvt(sumClr[gi]),
        .flag(summary[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // register reads, writes and the pin
  // ----------------------------------------
  logic [7:0] pwrNext;
  assign pwrNext = pwrClrRead ? pwrSet : (pwrEvt | pwrSet);
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdValid = 1'b0;
    if (regWr && (regCmd == `PIE_CMD_MASK)) begin
      st_nxt.mask = regWrData;
    end
    if (regRd) begin
      st_nxt.rdValid = 1'b1;
      case (regCmd)
        `PIE_CMD_SUMMARY: st_nxt.rdData = summary;
        `PIE_CMD_MASK: st_nxt.rdData = st_r.mask;
        `PIE_CMD_PWR_EVENT: st_nxt.rdData = pwrEvt;
        `PIE_CMD_PWR_EVENT_CLR: st_nxt.rdData = pwrEvt;
        default: st_nxt.rdData = 8'h00;
      endcase
    end
    // summary and mask both sampled from registers, so the pin trails by one
    st_nxt.intN = ~(globalInterruptEnable && |(summary & st_r.mask));
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r.mask <= `PIE_MASK_RST;
      st_r.rdData <= 8'h00;
      st_r.rdValid <= 1'b0;
      st_r.intN <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign regRdData = st_r.rdData;
  assign regRdValid = st_r.rdValid;
  assign intOut_n = st_r.intN;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_MASK_RESET: assert property (@(posedge clock)
    $past(sys_rst) |-> st_r.mask == `PIE_MASK_RST) else $error("mask reset wrong");
  AST_INT_FOLLOWS: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |->
    intOut_n == ~($past(globalInterruptEnable) && |($past(summary) & $past(st_r.mask))))
    else $error("interrupt pin wrong");
  AST_GLOBAL_OFF: assert property (@(posedge clock) disable iff (sys_rst)
    !globalInterruptEnable |=> intOut_n) else $error("pin low with enable off");
  AST_MASKED_OFF: assert property (@(posedge clock) disable iff (sys_rst)
    (st_r.mask == 8'h00) |=> intOut_n) else $error("pin low with all masked");
  AST_PWR_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
    pwrClrRead && !(|pwrSet) |=> pwrEvt == 8'h00) else $error("clear read kept bits");
  AST_PWR_KEEP: assert property (@(posedge clock) disable iff (sys_rst)
    pwrClrRead && (|pwrSet) |=> pwrEvt == $past(pwrSet)) else $error("event lost");
  AST_SAME_DATA: assert property (@(posedge clock) disable iff (sys_rst)
    regRd && (regCmd == `PIE_CMD_PWR_EVENT || regCmd == `PIE_CMD_PWR_EVENT_CLR)
    |=> regRdValid && regRdData == $past(pwrEvt)) else $error("event read data wrong");
  AST_PG_SUMMARY: assert property (@(posedge clock) disable iff (sys_rst)
    (|pwrEvt[7:4]) && !sumClr[`PIE_BIT_PGOOD] |=> summary[`PIE_BIT_PGOOD])
    else $error("power-good summary missed");
  AST_DET_SUMMARY: assert property (@(posedge clock) disable iff (sys_rst)
    (|channelDetectionEvent) |=> summary[`PIE_BIT_DETECT]) else $error("detect missed");
  AST_SUPPLY: assert property (@(posedge clock) disable iff (sys_rst)
    sumSet[`PIE_BIT_SUPPLY] |=> summary[`PIE_BIT_SUPPLY]) else $error("supply missed");
  AST_PWR_TRACK: assert property (@(posedge clock) disable iff (sys_rst)
    !sys_rst |=> pwrEvt == $past(pwrNext)) else $error("event register wrong");
  AST_START_SUMMARY: assert property (@(posedge clock) disable iff (sys_rst)
    (|channelStartFault) |=> summary[`PIE_BIT_START]) else $error("start missed");
  AST_OVERCUR_SUMMARY: assert property (@(posedge clock) disable iff (sys_rst)
    (|channelOverloadCut) || (|pairedChannelOverloadCut) || (|channelCurrentLimitFault)
    |=> summary[`PIE_BIT_OVERCUR]) else $error("overcurrent missed");
  AST_CLASS_SUMMARY: assert property (@(posedge clock) disable iff (sys_rst)
    (|channelClassificationEvent) |=> summary[`PIE_BIT_CLASS]) else $error("class missed");
  AST_DISC_SUMMARY: assert property (@(posedge clock) disable iff (sys_rst)
    (|channelDisconnectEvent) |=> summary[`PIE_BIT_DISC]) else $error("disc missed");
  AST_PE_SUMMARY: assert property (@(posedge clock) disable iff (sys_rst)
    (|pwrEvt[3:0]) && !sumClr[`PIE_BIT_PENABLE] |=> summary[`PIE_BIT_PENABLE])
    else $error("power-enable summary missed");
  AST_CLEAR_ALL: assert property (@(posedge clock) disable iff (sys_rst)
    summaryClearAll && !(|sumSet) |=> summary == 8'h00) else $error("clear all failed");
  AST_PWR_SUM_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
    pwrClrRead && !summaryClearAll |=> !summary[`PIE_BIT_PGOOD] && !summary[`PIE_BIT_PENABLE])
    else $error("clearing read kept summary");
  COV_INT_LOW: cover property (@(posedge clock) disable iff (sys_rst) !intOut_n);
  COV_CLR_RELEASE: cover property (@(posedge clock) disable iff (sys_rst)
    !intOut_n && pwrClrRead ##2 intOut_n);
  COV_MASK_WR: cover property (@(posedge clock) disable iff (sys_rst)
    regWr && regCmd == `PIE_CMD_MASK);
endmodule : pie_interrupt_event_logic

// ==== bench/pie_host_model.sv ====
// host-side register access model for the interrupt logic
`timescale 1ns/1ps
module pie_host_model (
  // clock
  input wire logic clock,
  // register access
  output logic regRd,
  output logic regWr,
  output logic [7:0] regCmd,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  initial begin
    regRd = 1'b0;
    regWr = 1'b0;
    regCmd = 8'h5a;
    regWrData = 8'ha5;
  end
  // --------------------------------------------------
  // accesses
  // --------------------------------------------------
  // between strobes code and data show junk, never the last value
  task automatic rd(input logic [7:0] cmd, output logic [7:0] data, output logic vld);
    @(negedge clock);
    regRd = 1'b1;
    regCmd = cmd;
    @(negedge clock);
    regRd = 1'b0;
    regCmd = ~cmd;
    data = regRdData;
    vld = regRdValid;
  endtask : rd
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    @(negedge clock);
    regWr = 1'b1;
    regCmd = cmd;
    regWrData = data;
    @(negedge clock);
    regWr = 1'b0;
    regCmd = ~cmd;
    regWrData = ~data;
  endtask : wr
endmodule : pie_host_model

// ==== bench/pie_interrupt_event_logic_tb.sv ====
// self-checking testbench for the interrupt logic
`timescale 1ns/1ps
module pie_interrupt_event_logic_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic gEn = 1'b0;
  logic [18:0] src = 19'h00000;
  logic regRd, regWr, regRdValid, intOut_n;
  logic [7:0] regCmd, regWrData, regRdData, e;
  int b;
  int errCount = 0;
  int checkCount = 0;
  pie_host_model host_u (.clock, .regRd, .regWr, .regCmd, .regWrData, .regRdData, .regRdValid);
  pie_interrupt_event_logic dut_u (.clock, .sys_rst, .regRd, .regWr, .regCmd, .regWrData,
    .regRdData, .regRdValid, .summaryClearAll(src[14]), .startFaultRead(src[15]),
    .overcurFaultRead(src[16]), .detectEventRead(src[17]), .faultEventRead(src[18]),
    .thermalShutdownFlag(src[7]), .digitalSupplyUndervoltage(src[8]),
    .digitalSupplyWarning(src[9]), .powerSupplyUndervoltage(src[10]),
    .programMemoryFault(src[11]), .channelStartFault({src[6], 3'h0}),
    .channelOverloadCut({3'h0, src[12]}), .pairedChannelOverloadCut({src[5], 1'b0}),
    .channelCurrentLimitFault({src[13], 3'h0}), .channelClassificationEvent({1'b0, src[4], 2'h0}),
    .channelDetectionEvent({2'h0, src[3], 1'b0}), .channelDisconnectEvent({3'h0, src[2]}),
    .channelPowerGoodChange({3'h0, src[1]}), .channelPowerEnableChange({src[0], 3'h0}),
    .globalInterruptEnable(gEn), .intOut_n);
  initial begin
    forever #2 clock = ~clock;
  end
  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host_u.rd(cmd, d, v);
    chk("read valid", {7'h00, v}, 8'h01);
    chk("read data", d, exp);
  endtask : rdc
  task automatic pulse(input int i);
    @(negedge clock);
    src[i] = 1'b1;
    @(negedge clock);
    src[i] = 1'b0;
  endtask : pulse
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : printVerdict
  initial begin
    #20000;
    errCount++;
    printVerdict();
  end
  // --------------------------------------------------
  // tests
  // --------------------------------------------------
  initial begin
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    rdc(8'h01, 8'h80);
    rdc(8'h00, 8'h80);
    host_u.wr(8'h01, 8'h00);
    gEn = 1'b1;
    // power-event sources last so the power-event bits stay set for the next test
    for (int i = 13; i >= 0; i--) begin
      pulse(14);
      pulse(i);
      b = i < 8 ? i : (i < 12 ? 7 : 5);
      e = (i == 0 ? 8'h02 : 8'h00) | (8'h01 << b);
      rdc(8'h00, e);
      chk("int masked", {7'h00, intOut_n}, 8'h01);
    end
    $display("test summary sources done");
    rdc(8'h02, 8'h18);
    rdc(8'h03, 8'h18);
    rdc(8'h02, 8'h00);
    rdc(8'h00, 8'h00);
    rdc(8'h7e, 8'h00);
    $display("test power event done");
    host_u.wr(8'h01, 8'h08);
    pulse(3);
    repeat (2) @(negedge clock);
    chk("int set", {7'h00, intOut_n}, 8'h00);
    gEn = 1'b0;
    repeat (2) @(negedge clock);
    chk("int no enable", {7'h00, intOut_n}, 8'h01);
    gEn = 1'b1;
    pulse(14);
    repeat (2) @(negedge clock);
    chk("int cleared", {7'h00, intOut_n}, 8'h01);
    host_u.wr(8'h01, 8'h03);
    rdc(8'h01, 8'h03);
    pulse(1);
    repeat (3) @(negedge clock);
    chk("int power", {7'h00, intOut_n}, 8'h00);
    rdc(8'h03, 8'h10);
    repeat (2) @(negedge clock);
    chk("int released", {7'h00, intOut_n}, 8'h01);
    $display("test interrupt output done");
    // reads of the other event registers clear their own summary bits only
    pulse(6);
    pulse(4);
    pulse(12);
    pulse(2);
    rdc(8'h00, 8'h74);
    pulse(15);
    rdc(8'h00, 8'h34);
    pulse(17);
    rdc(8'h00, 8'h24);
    pulse(16);
    rdc(8'h00, 8'h04);
    pulse(12);
    pulse(18);
    rdc(8'h00, 8'h00);
    $display("test summary clears done");
    printVerdict();
  end
endmodule : pie_interrupt_event_logic_tb
